// ---- rtl/fcl_limit_regs.sv ----
// Local design decision: the strobed register port.
`timescale 1ns/10ps
// Functional notes
// - Lock bit makes acoustic, start, critical and hysteresis registers ignore writes.
// - Floor duty registers ignore writes while automatic mode is on.
// - Floor duty is linear 8-bit: 0 off, 0x40 quarter, 0x80 half, 0xff full.
// - Above its start temperature a channel runs its fan at floor duty.
// - Any channel above its critical limit forces every PWM to full duty.
// - Critical limit value 0x80 disables that channel's fail-safe.
// - Forced full duty holds until temperature falls below limit minus hysteresis.
// - Overtemperature pin, if an output, pulls low a quarter degree above limit.
// - Hysteresis nibbles: local 0x6d[3:0], remote one 0x6d[7:4], remote two 0x6e[7:4].
// - Below start, fan stays at floor duty until start minus hysteresis.
// - Each hysteresis field means 0 to 15 degrees in one-degree steps.
module fcl_limit_regs (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [9:0] i_temp_remote_one,
  input wire logic [9:0] i_temp_local,
  input wire logic [9:0] i_temp_remote_two,
  output logic [7:0] o_pwm_one_duty,
  output logic [7:0] o_pwm_two_duty,
  output logic [7:0] o_pwm_three_duty,
  output logic o_full_speed,
  input wire logic i_critical_overtemp_pin,
  output logic o_critical_overtemp_pin,
  output logic o_critical_overtemp_pin_oe,
  output logic o_irq
);
  import fcl_pkg::*;

  // ****************************************************************************
  // State.
  // ****************************************************************************
  typedef struct packed {
    logic [7:0] acoustic;
    logic [FCL_NCH-1:0][7:0] floor_duty;
    logic [FCL_NCH-1:0][7:0] start_temp;
    logic [FCL_NCH-1:0][7:0] crit_limit;
    logic [7:0] hyst_a;
    logic [7:0] hyst_b;
    logic lock;
    logic automatic_cooling_loop;
    logic pin_out;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [7:0] rdata;
    logic [FCL_NCH-1:0][7:0] duty;
    logic full_speed;
    logic pin_oe;
    logic irq;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
  } fcl_state_type;

  fcl_state_type s_r;
  fcl_state_type s_nxt;
  logic [FCL_NCH-1:0][9:0] temp;
  logic [FCL_NCH-1:0][3:0] hyst;
  logic [FCL_NCH-1:0] run;
  logic [FCL_NCH-1:0] crit;
  logic [FCL_NCH-1:0] trip;

  assign temp[FCL_CH_REMOTE_ONE] = i_temp_remote_one;
  assign temp[FCL_CH_LOCAL] = i_temp_local;
  assign temp[FCL_CH_REMOTE_TWO] = i_temp_remote_two;

  // Hysteresis nibbles picked out of the two shared registers.
  assign hyst[FCL_CH_LOCAL] = s_r.hyst_a[FCL_HYST_LO +: 4];
  assign hyst[FCL_CH_REMOTE_ONE] = s_r.hyst_a[FCL_HYST_HI +: 4];
  assign hyst[FCL_CH_REMOTE_TWO] = s_r.hyst_b[FCL_HYST_HI +: 4];

  // ****************************************************************************
  // Per-channel threshold logic.
  // ****************************************************************************
  for (genvar g = 0; g < FCL_NCH; g++) begin : g_chan
    fcl_chan u_chan (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_temp(temp[g]),
      .i_start(s_r.start_temp[g]),
      .i_limit(s_r.crit_limit[g]),
      .i_hyst(hyst[g]),
      .o_run(run[g]),
      .o_crit(crit[g]),
      .o_trip(trip[g])
    );
  end

  // ****************************************************************************
  // Register writes, reads, fan duty and interrupt.
  // ****************************************************************************
  always_comb begin
    logic reject;
    logic [3:0] events;
    reject = 1'b0;
    events = 4'h0;
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    // The pin input passes through four flops before anything looks at it.
    s_nxt.pin_meta = {s_r.pin_meta[0], i_critical_overtemp_pin};
    s_nxt.pin_sync = {s_r.pin_sync[0], s_r.pin_meta[1]};

    if (i_wr) begin
      case (i_addr)
        FCL_ADDR_ACOUSTIC_ENHANCE_SECOND: begin
          if (s_r.lock) reject = 1'b1;
          else s_nxt.acoustic = i_wdata;
        end
        FCL_ADDR_PWM_ONE_FLOOR_DUTY, FCL_ADDR_PWM_TWO_FLOOR_DUTY, FCL_ADDR_PWM_THREE_FLOOR_DUTY: begin
          if (s_r.automatic_cooling_loop) begin
            reject = 1'b1;
          end else begin
            s_nxt.floor_duty[i_addr[1:0] - 2'd0] = i_wdata;
          end
        end
        FCL_ADDR_REMOTE_ONE_START_TEMP, FCL_ADDR_LOCAL_START_TEMP, FCL_ADDR_REMOTE_TWO_START_TEMP: begin
          if (s_r.lock) reject = 1'b1;
          else s_nxt.start_temp[2'(i_addr - FCL_ADDR_REMOTE_ONE_START_TEMP)] = i_wdata;
        end
        FCL_ADDR_REMOTE_ONE_CRITICAL_LIMIT, FCL_ADDR_LOCAL_CRITICAL_LIMIT,
        FCL_ADDR_REMOTE_TWO_CRITICAL_LIMIT: begin
          if (s_r.lock) reject = 1'b1;
          else s_nxt.crit_limit[2'(i_addr - FCL_ADDR_REMOTE_ONE_CRITICAL_LIMIT)] = i_wdata;
        end
        FCL_ADDR_LOCAL_REMOTE_ONE_HYSTERESIS: begin
          if (s_r.lock) reject = 1'b1;
          else s_nxt.hyst_a = i_wdata;
        end
        FCL_ADDR_REMOTE_TWO_HYSTERESIS: begin
          if (s_r.lock) reject = 1'b1;
          else s_nxt.hyst_b = i_wdata;
        end
        FCL_ADDR_CONTROL: begin
          // The lock can only be set; it falls again only with reset.
          s_nxt.lock = s_r.lock | i_wdata[FCL_CTRL_LOCK_BIT];
          s_nxt.automatic_cooling_loop = i_wdata[FCL_CTRL_AUTO_BIT];
          s_nxt.pin_out = i_wdata[FCL_CTRL_PIN_OUT_BIT];
        end
        FCL_ADDR_IRQ_CLEAR: begin
          s_nxt.irq_status = s_r.irq_status & ~i_wdata[3:0];
        end
        FCL_ADDR_IRQ_ENABLE: begin
          s_nxt.irq_enable = i_wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // Events are applied after the clear so that a set in the same cycle wins.
    events = {reject, trip};
    s_nxt.irq_status = s_nxt.irq_status | events;
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_enable);

    if (i_rd) begin
      case (i_addr)
        FCL_ADDR_ACOUSTIC_ENHANCE_SECOND: s_nxt.rdata = s_r.acoustic;
        FCL_ADDR_PWM_ONE_FLOOR_DUTY: s_nxt.rdata = s_r.floor_duty[0];
        FCL_ADDR_PWM_TWO_FLOOR_DUTY: s_nxt.rdata = s_r.floor_duty[1];
        FCL_ADDR_PWM_THREE_FLOOR_DUTY: s_nxt.rdata = s_r.floor_duty[2];
        FCL_ADDR_REMOTE_ONE_START_TEMP: s_nxt.rdata = s_r.start_temp[0];
        FCL_ADDR_LOCAL_START_TEMP: s_nxt.rdata = s_r.start_temp[1];
        FCL_ADDR_REMOTE_TWO_START_TEMP: s_nxt.rdata = s_r.start_temp[2];
        FCL_ADDR_REMOTE_ONE_CRITICAL_LIMIT: s_nxt.rdata = s_r.crit_limit[0];
        FCL_ADDR_LOCAL_CRITICAL_LIMIT: s_nxt.rdata = s_r.crit_limit[1];
        FCL_ADDR_REMOTE_TWO_CRITICAL_LIMIT: s_nxt.rdata = s_r.crit_limit[2];
        FCL_ADDR_LOCAL_REMOTE_ONE_HYSTERESIS: s_nxt.rdata = s_r.hyst_a;
        FCL_ADDR_REMOTE_TWO_HYSTERESIS: s_nxt.rdata = s_r.hyst_b;
        FCL_ADDR_CONTROL: s_nxt.rdata = {5'h00, s_r.pin_out, s_r.automatic_cooling_loop, s_r.lock};
        FCL_ADDR_IRQ_STATUS: s_nxt.rdata = {4'h0, s_r.irq_status};
        FCL_ADDR_IRQ_ENABLE: s_nxt.rdata = {4'h0, s_r.irq_enable};
        FCL_ADDR_LOOP_STATE: s_nxt.rdata = {s_r.pin_sync[1], crit, 1'b0, run};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Any tripped channel overrides every PWM, whatever mode is set.
    s_nxt.full_speed = |crit;
    for (int i = 0; i < FCL_NCH; i++) begin
      if (crit != '0) begin
        s_nxt.duty[i] = FCL_DUTY_FULL;
      end else if (!s_r.automatic_cooling_loop) begin
        s_nxt.duty[i] = s_r.floor_duty[i];
      end else if (run[i]) begin
        s_nxt.duty[i] = s_r.floor_duty[i];
      end else begin
        s_nxt.duty[i] = FCL_DUTY_OFF;
      end
    end

    // Open drain: the pin is only ever pulled low, never driven high.
    s_nxt.pin_oe = s_r.pin_out & (|crit);
  end

  // State register.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.acoustic <= FCL_RST_ACOUSTIC;
      s_r.floor_duty <= {FCL_NCH{FCL_RST_FLOOR_DUTY}};
      s_r.start_temp <= {FCL_NCH{FCL_RST_START_TEMP}};
      s_r.crit_limit <= {FCL_NCH{FCL_RST_CRITICAL_LIMIT}};
      s_r.hyst_a <= FCL_RST_HYST_A;
      s_r.hyst_b <= FCL_RST_HYST_B;
      s_r.irq_status <= FCL_RST_IRQ;
      s_r.irq_enable <= FCL_RST_IRQ;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_pwm_one_duty = s_r.duty[0];
  assign o_pwm_two_duty = s_r.duty[1];
  assign o_pwm_three_duty = s_r.duty[2];
  assign o_full_speed = s_r.full_speed;
  assign o_critical_overtemp_pin = 1'b0;
  assign o_critical_overtemp_pin_oe = s_r.pin_oe;
  assign o_irq = s_r.irq;

endmodule

// ---- rtl/fcl_pkg.sv ----
// ****************************************************************************
// Constants shared by the fan control limit register bank.
// ****************************************************************************
package fcl_pkg;

  // Number of temperature channels and of PWM outputs they steer.
  localparam int FCL_NCH = 3;

  // Channel order: 0 is remote one, 1 is local, 2 is remote two.
  localparam int FCL_CH_REMOTE_ONE = 0;
  localparam int FCL_CH_LOCAL = 1;
  localparam int FCL_CH_REMOTE_TWO = 2;

  // ****************************************************************************
  // Register offsets.
  // ****************************************************************************
  localparam logic [7:0] FCL_ADDR_ACOUSTIC_ENHANCE_SECOND = 8'h63;
  localparam logic [7:0] FCL_ADDR_PWM_ONE_FLOOR_DUTY = 8'h64;
  localparam logic [7:0] FCL_ADDR_PWM_TWO_FLOOR_DUTY = 8'h65;
  localparam logic [7:0] FCL_ADDR_PWM_THREE_FLOOR_DUTY = 8'h66;
  localparam logic [7:0] FCL_ADDR_REMOTE_ONE_START_TEMP = 8'h67;
  localparam logic [7:0] FCL_ADDR_LOCAL_START_TEMP = 8'h68;
  localparam logic [7:0] FCL_ADDR_REMOTE_TWO_START_TEMP = 8'h69;
  localparam logic [7:0] FCL_ADDR_REMOTE_ONE_CRITICAL_LIMIT = 8'h6a;
  localparam logic [7:0] FCL_ADDR_LOCAL_CRITICAL_LIMIT = 8'h6b;
  localparam logic [7:0] FCL_ADDR_REMOTE_TWO_CRITICAL_LIMIT = 8'h6c;
  localparam logic [7:0] FCL_ADDR_LOCAL_REMOTE_ONE_HYSTERESIS = 8'h6d;
  localparam logic [7:0] FCL_ADDR_REMOTE_TWO_HYSTERESIS = 8'h6e;
  localparam logic [7:0] FCL_ADDR_CONTROL = 8'h50;
  localparam logic [7:0] FCL_ADDR_IRQ_STATUS = 8'h51;
  localparam logic [7:0] FCL_ADDR_IRQ_CLEAR = 8'h52;
  localparam logic [7:0] FCL_ADDR_IRQ_ENABLE = 8'h53;
  localparam logic [7:0] FCL_ADDR_LOOP_STATE = 8'h54;

  // ****************************************************************************
  // Values after reset.
  // ****************************************************************************
  localparam logic [7:0] FCL_RST_ACOUSTIC = 8'h00;
  localparam logic [7:0] FCL_RST_FLOOR_DUTY = 8'h80;
  localparam logic [7:0] FCL_RST_START_TEMP = 8'h5a;
  localparam logic [7:0] FCL_RST_CRITICAL_LIMIT = 8'h64;
  localparam logic [7:0] FCL_RST_HYST_A = 8'h44;
  localparam logic [7:0] FCL_RST_HYST_B = 8'h40;
  localparam logic [7:0] FCL_RST_CONTROL = 8'h00;
  localparam logic [3:0] FCL_RST_IRQ = 4'h0;

  // ****************************************************************************
  // Field positions and special values.
  // ****************************************************************************
  localparam int FCL_CTRL_LOCK_BIT = 0;
  localparam int FCL_CTRL_AUTO_BIT = 1;
  localparam int FCL_CTRL_PIN_OUT_BIT = 2;
  localparam int FCL_EVT_REJECT_BIT = 3;
  localparam int FCL_HYST_LO = 0;
  localparam int FCL_HYST_HI = 4;
  localparam logic [7:0] FCL_LIMIT_DISABLE = 8'h80;
  localparam logic [7:0] FCL_DUTY_FULL = 8'hff;
  localparam logic [7:0] FCL_DUTY_OFF = 8'h00;

endpackage

// ---- rtl/fcl_chan.sv ----
`timescale 1ns/10ps
// ****************************************************************************
// One temperature channel: start threshold and critical trip, each with
// hysteresis. Temperatures are in quarter degrees (8 integer, 2 fraction bits).
// ****************************************************************************
module fcl_chan (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [9:0] i_temp,
  input wire logic [7:0] i_start,
  input wire logic [7:0] i_limit,
  input wire logic [3:0] i_hyst,
  output logic o_run,
  output logic o_crit,
  output logic o_trip
);
  import fcl_pkg::*;

  typedef struct packed {
    logic run;
    logic crit;
    logic trip;
  } fcl_chan_type;

  fcl_chan_type s_r;
  fcl_chan_type s_nxt;
  logic signed [11:0] temp_q;
  logic signed [11:0] start_q;
  logic signed [11:0] start_low_q;
  logic signed [11:0] limit_q;
  logic signed [11:0] limit_low_q;

  // All thresholds are widened and signed so that a hysteresis larger than
  // the threshold gives a negative floor instead of wrapping around.
  assign temp_q = $signed({2'b00, i_temp});
  assign start_q = $signed({2'b00, i_start, 2'b00});
  assign start_low_q = start_q - $signed({6'h00, i_hyst, 2'b00});
  assign limit_q = $signed({2'b00, i_limit, 2'b00});
  assign limit_low_q = limit_q - $signed({6'h00, i_hyst, 2'b00});

  // Next state of the start and critical latches.
  always_comb begin
    s_nxt = s_r;
    s_nxt.trip = 1'b0;
    if (temp_q > start_q) begin
      s_nxt.run = 1'b1;
    end else if (temp_q <= start_low_q) begin
      s_nxt.run = 1'b0;
    end
    if (i_limit == FCL_LIMIT_DISABLE) begin
      s_nxt.crit = 1'b0;
    end else if (temp_q > limit_q) begin
      s_nxt.crit = 1'b1;
      s_nxt.trip = ~s_r.crit;
    end else if (temp_q < limit_low_q) begin
      s_nxt.crit = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_run = s_r.run;
  assign o_crit = s_r.crit;
  assign o_trip = s_r.trip;

endmodule

// ---- verif/fcl_limit_monitor.sv ----
`timescale 1ns/10ps
// ********************
// Port checks for the fan control limit bank.
// ********************
module fcl_limit_monitor (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_pwm_one_duty,
  input wire logic [7:0] o_pwm_two_duty,
  input wire logic [7:0] o_pwm_three_duty,
  input wire logic o_full_speed,
  input wire logic o_critical_overtemp_pin,
  input wire logic o_critical_overtemp_pin_oe,
  input wire logic o_irq
);
  import fcl_pkg::*;
  logic lock_r;
  logic auto_r;
  logic pin_r;
  logic [7:0] start_r;
  logic [7:0] floor_r;
  logic [1:0] age_r;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Shadows of lock, mode and two registers; age keeps the first cycles after reset out of the duty check.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lock_r <= 1'b0;
      auto_r <= 1'b0;
      pin_r <= 1'b0;
      start_r <= FCL_RST_START_TEMP;
      floor_r <= FCL_RST_FLOOR_DUTY;
      age_r <= 2'h0;
    end else begin
      if (i_wr && i_addr == FCL_ADDR_CONTROL) begin
        lock_r <= lock_r | i_wdata[FCL_CTRL_LOCK_BIT];
        auto_r <= i_wdata[FCL_CTRL_AUTO_BIT];
        pin_r <= i_wdata[FCL_CTRL_PIN_OUT_BIT];
      end
      if (i_wr && i_addr == FCL_ADDR_REMOTE_ONE_START_TEMP && !lock_r) begin
        start_r <= i_wdata;
      end
      if (i_wr && i_addr == FCL_ADDR_PWM_ONE_FLOOR_DUTY && !auto_r) begin
        floor_r <= i_wdata;
      end
      if (age_r != 2'h3) begin
        age_r <= age_r + 2'h1;
      end
    end
  end
  property p_forced_full;
    o_full_speed |-> (o_pwm_one_duty & o_pwm_two_duty & o_pwm_three_duty) == FCL_DUTY_FULL;
  endproperty
  a_forced_full: assert property (p_forced_full) else $error("duty not full while tripped");
  property p_pin_low;
    o_critical_overtemp_pin == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_oe_trip;
    o_critical_overtemp_pin_oe |-> o_full_speed;
  endproperty
  a_oe_trip: assert property (p_oe_trip) else $error("pin pulled without trip");
  // The pull must also appear whenever a trip meets an output-mode pin, not only vanish without one.
  property p_oe_follow;
    o_critical_overtemp_pin_oe == ($past(pin_r) && o_full_speed);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin pull not following trip and mode");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_irq_mask;
    i_wr && i_addr == FCL_ADDR_IRQ_ENABLE && i_wdata == 8'h00 ##1 !(i_wr && i_addr == FCL_ADDR_IRQ_ENABLE) |=> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq high while masked");
  property p_lock_start;
    i_rd && i_addr == FCL_ADDR_REMOTE_ONE_START_TEMP |=> o_rdata == start_r;
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("start temp read wrong");
  property p_floor_auto;
    i_rd && i_addr == FCL_ADDR_PWM_ONE_FLOOR_DUTY |=> o_rdata == floor_r;
  endproperty
  a_floor_auto: assert property (p_floor_auto) else $error("floor duty read wrong");
  property p_manual_duty;
    age_r == 2'h3 && !auto_r && !$past(auto_r) && $stable(floor_r) && !o_full_speed && !$past(o_full_speed)
      |-> o_pwm_one_duty == floor_r;
  endproperty
  a_manual_duty: assert property (p_manual_duty) else $error("manual duty not floor");
endmodule

// ---- verif/fcl_thermal_env.sv ----
`timescale 1ns/10ps
// ********************
// Sensors and pulled-up pin seen by the bank.
// ********************
module fcl_thermal_env (
  input wire logic i_clock,
  input wire logic [9:0] i_heat [3],
  input wire logic i_drive,
  input wire logic i_pull_low,
  output logic [9:0] o_temp [3],
  output logic o_pin_level
);
  // Sensors report one clock late, as a converter would.
  always_ff @(posedge i_clock) begin
    o_temp <= i_heat;
  end
  // The pull-up wins whenever the bank lets go of the pin.
  assign o_pin_level = i_pull_low ? i_drive : 1'b1;
endmodule

// ---- verif/tb_fcl_limit_regs.sv ----
`timescale 1ns/10ps
// ********************
// Self-checking bench for the fan control limit bank.
// ********************
module tb_fcl_limit_regs;
  import fcl_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [9:0] heat [3] = '{10'h0, 10'h0, 10'h0};
  logic [9:0] temp [3];
  logic [7:0] duty [3];
  logic [7:0] o_rdata;
  logic full, pin_out, pin_oe, irq, pin;
  int mismatches = 0;
  int tests_run = 0;
  fcl_limit_regs i_fcl_limit_regs (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_temp_remote_one(temp[0]), .i_temp_local(temp[1]),
    .i_temp_remote_two(temp[2]), .o_pwm_one_duty(duty[0]), .o_pwm_two_duty(duty[1]), .o_pwm_three_duty(duty[2]),
    .o_full_speed(full), .i_critical_overtemp_pin(pin), .o_critical_overtemp_pin(pin_out),
    .o_critical_overtemp_pin_oe(pin_oe), .o_irq(irq));
  fcl_thermal_env i_fcl_thermal_env (.i_clock(i_clock), .i_heat(heat), .i_drive(pin_out), .i_pull_low(pin_oe),
    .o_temp(temp), .o_pin_level(pin));
  // Clock of 50 ns.
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // Read data exist only in the cycle after the strobe, so sample mid-cycle there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    d = o_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk("read data", d, exp);
  endtask
  // Sensor, channel and output flops need three edges; four leave margin.
  task automatic heat_to(input int ch, input logic [9:0] t);
    @(posedge i_clock);
    heat[ch] <= t;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  task automatic s_reset_values();
    logic [7:0] rv [12] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40};
    for (int k = 0; k < 12; k++) begin
      rd_chk(8'h63 + 8'(k), rv[k]);
    end
    rd_chk(8'h7f, 8'h00);
    chk("duty after reset", duty[0], 8'h80);
  endtask
  task automatic s_floor();
    logic [7:0] codes [4] = '{8'h00, 8'h40, 8'h80, 8'hff};
    foreach (codes[k]) begin
      for (int p = 0; p < 3; p++) wr(FCL_ADDR_PWM_ONE_FLOOR_DUTY + 8'(p), codes[k]);
      rd_chk(FCL_ADDR_PWM_THREE_FLOOR_DUTY, codes[k]);
      for (int p = 0; p < 3; p++) chk("floor duty", duty[p], codes[k]);
    end
    wr(FCL_ADDR_IRQ_ENABLE, 8'h08);
    wr(FCL_ADDR_CONTROL, 8'h02);
    wr(FCL_ADDR_PWM_TWO_FLOOR_DUTY, 8'h33);
    rd_chk(FCL_ADDR_PWM_TWO_FLOOR_DUTY, 8'hff);
    heat_to(0, 10'h0);
    chk("auto idle duty", duty[1], 8'h00);
    chk("refusal irq", irq, 1'b1);
    wr(FCL_ADDR_IRQ_ENABLE, 8'h00);
    wr(FCL_ADDR_IRQ_CLEAR, 8'h08);
    rd_chk(FCL_ADDR_IRQ_STATUS, 8'h00);
  endtask
  // Trip one channel at the reset limit of 100 degrees, then walk down through its hysteresis.
  task automatic s_trip(input int ch, input logic [3:0] hy);
    wr(FCL_ADDR_IRQ_ENABLE, 8'h07);
    heat_to(ch, 10'd400);
    chk("full at limit", full, 1'b0);
    heat_to(ch, 10'd401);
    chk("full above limit", full, 1'b1);
    for (int p = 0; p < 3; p++) chk("forced duty", duty[p], 8'hff);
    chk("pin level", pin, 1'b0);
    chk("trip irq", irq, 1'b1);
    heat_to(ch, 10'd400 - 10'({hy, 2'b00}));
    chk("full held", full, 1'b1);
    rd_chk(FCL_ADDR_LOOP_STATE, 8'(8'h11 << ch));
    heat_to(ch, 10'd399 - 10'({hy, 2'b00}));
    chk("full released", full, 1'b0);
    chk("pin released", pin, 1'b1);
    wr(FCL_ADDR_IRQ_CLEAR, 8'h07);
    rd_chk(FCL_ADDR_LOOP_STATE, 8'h80 | 8'(8'h01 << ch));
    heat_to(ch, 10'h0);
    chk("irq cleared", irq, 1'b0);
  endtask
  task automatic s_crit();
    wr(FCL_ADDR_CONTROL, 8'h04);
    for (int p = 0; p < 3; p++) wr(FCL_ADDR_PWM_ONE_FLOOR_DUTY + 8'(p), 8'h40);
    wr(FCL_ADDR_LOCAL_REMOTE_ONE_HYSTERESIS, 8'h47);
    wr(FCL_ADDR_REMOTE_TWO_HYSTERESIS, 8'hc0);
    s_trip(0, 4'h4);
    s_trip(1, 4'h7);
    s_trip(2, 4'hc);
    wr(FCL_ADDR_LOCAL_CRITICAL_LIMIT, FCL_LIMIT_DISABLE);
    heat_to(1, 10'h3fc);
    chk("disabled limit", full, 1'b0);
    heat_to(1, 10'h0);
  endtask
  // Remote two starts at 90 degrees with 12 degrees of hysteresis in automatic mode.
  task automatic s_start();
    wr(FCL_ADDR_CONTROL, 8'h02);
    heat_to(2, 10'd360);
    chk("below start", duty[2], 8'h00);
    heat_to(2, 10'd361);
    chk("above start", duty[2], 8'h40);
    chk("other fan idle", duty[0], 8'h00);
    heat_to(2, 10'd313);
    chk("in hysteresis", duty[2], 8'h40);
    heat_to(2, 10'd312);
    chk("hysteresis end", duty[2], 8'h00);
  endtask
  task automatic s_lock();
    logic [7:0] locked [9] = '{8'h63, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e};
    logic [7:0] was;
    wr(FCL_ADDR_CONTROL, 8'h01);
    wr(FCL_ADDR_CONTROL, 8'h00);
    rd_chk(FCL_ADDR_CONTROL, 8'h01);
    foreach (locked[k]) begin
      rd(locked[k], was);
      wr(locked[k], ~was);
      rd_chk(locked[k], was);
    end
    wr(FCL_ADDR_PWM_ONE_FLOOR_DUTY, 8'h11);
    rd_chk(FCL_ADDR_PWM_ONE_FLOOR_DUTY, 8'h11);
    rd_chk(FCL_ADDR_IRQ_STATUS, 8'h08);
  endtask
  // A reset in mid-run is the only way back out of the lock.
  task automatic s_unlock();
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_chk(FCL_ADDR_CONTROL, 8'h00);
    wr(FCL_ADDR_REMOTE_ONE_START_TEMP, 8'h55);
    rd_chk(FCL_ADDR_REMOTE_ONE_START_TEMP, 8'h55);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset for eight cycles, then each scenario in turn; the lock comes just before the mid-run reset, as only reset undoes it.
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    s_reset_values();
    s_floor();
    s_crit();
    s_start();
    s_lock();
    s_unlock();
    stop_test();
  end
endmodule
bind fcl_limit_regs fcl_limit_monitor i_fcl_limit_monitor (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm_one_duty(o_pwm_one_duty),
  .o_pwm_two_duty(o_pwm_two_duty), .o_pwm_three_duty(o_pwm_three_duty), .o_full_speed(o_full_speed),
  .o_critical_overtemp_pin(o_critical_overtemp_pin), .o_critical_overtemp_pin_oe(o_critical_overtemp_pin_oe),
  .o_irq(o_irq));
